//--- src/trs_tlb_replacement_select.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module trs_tlb_replacement_select
	import trs_pkg::*;
#(
	parameter int NUM_FULL   = 16,
	parameter int FULL_IDX_W = 4,
	parameter int NUM_SETS   = 64,
	parameter int SET_IDX_W  = 6,
	parameter int VA_W       = 48,
	parameter int ADDR_W     = 8
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       irq,
	input  wire logic                  refill_valid,
	input  wire logic                  refill_is_fetch,
	input  wire logic [2:0]            refill_page_size,
	input  wire logic                  refill_locked,
	input  wire logic                  refill_global,
	input  wire logic [VA_W-1:0]       refill_tag_addr,
	output logic                       refill_done,
	output logic                       refill_to_two_way,
	output logic                       refill_dropped,
	output logic [FULL_IDX_W-1:0]      refill_entry,
	output logic [SET_IDX_W-1:0]       refill_set_index,
	output logic                       refill_way,
	input  wire logic                  lookup_valid,
	input  wire logic [NUM_FULL-1:0]   lookup_match,
	input  wire logic                  lookup_identical,
	output logic                       lookup_hit,
	output logic [FULL_IDX_W-1:0]      lookup_entry,
	output logic                       lookup_multi_hit,
	input  wire logic                  direct_full_we,
	input  wire logic [FULL_IDX_W-1:0] direct_full_entry,
	input  wire logic                  direct_full_valid,
	input  wire logic                  direct_full_lock,
	input  wire logic                  direct_two_we,
	input  wire logic [SET_IDX_W-1:0]  direct_two_set,
	input  wire logic                  direct_two_way,
	input  wire logic                  direct_two_valid,
	input  wire logic                  access_valid,
	input  wire logic                  access_alternate,
	input  wire logic                  access_use_imm,
	input  wire logic [7:0]            access_imm_asi,
	input  wire logic [7:0]            access_asi_reg,
	input  wire logic [7:0]            access_implicit_asi,
	input  wire logic                  privilege_flag,
	output logic                       access_done,
	output logic [7:0]                 access_asi,
	output logic                       access_priv_trap
);
	import trs_pkg::*;

	// ==================================================================
	// state
	typedef struct packed {
		trs_wstate_t                  wst;
		logic                         aw_got;
		logic                         w_got;
		logic [ADDR_W-1:0]            awaddr;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic [3:0]                   mem_ctrl;
		logic [15:0]                  ctx_sizes;
		logic [2:0]                   status;
		logic [2:0]                   mask;
		logic [31:0]                  refills;
		logic [NUM_FULL-1:0]          fvalid;
		logic [NUM_FULL-1:0]          flock;
		logic [NUM_FULL-1:0]          fused;
		logic [NUM_SETS-1:0][1:0]     tvalid;
		logic [NUM_SETS-1:0]          tnext;
		logic                         r_done;
		logic                         r_two;
		logic                         r_drop;
		logic [FULL_IDX_W-1:0]        r_entry;
		logic [SET_IDX_W-1:0]         r_set;
		logic                         r_way;
		logic                         l_hit;
		logic [FULL_IDX_W-1:0]        l_entry;
		logic                         l_multi;
		logic                         a_done;
		logic [7:0]                   a_asi;
		logic                         a_trap;
	} trs_state_t;

	trs_state_t st_reg;
	trs_state_t st_next;

	// ==================================================================
	// placement decision for fetch and data refills
	logic                  size_sel;
	logic                  force_full;
	logic [2:0]            ctx_a;
	logic [2:0]            ctx_b;
	logic                  size_ok;
	logic                  ok_two;
	logic [SET_IDX_W-1:0]  set_idx;
	logic [NUM_FULL-1:0]   eff_lock;
	logic                  all_locked;
	logic                  inv_found;
	logic [FULL_IDX_W-1:0] inv_idx;
	logic                  uu_found;
	logic [FULL_IDX_W-1:0] uu_idx;
	logic                  ul_found;
	logic [FULL_IDX_W-1:0] ul_idx;
	logic                  lm_found;
	logic [FULL_IDX_W-1:0] lm_idx;
	logic                  lm_many;
	logic [7:0]            sel_asi;

	always_comb
	begin
		size_sel   = refill_is_fetch ? st_reg.mem_ctrl[BIT_FETCH_SIZE_SELECT]
		                             : st_reg.mem_ctrl[BIT_DATA_SIZE_SELECT];
		force_full = refill_is_fetch ? st_reg.mem_ctrl[BIT_FETCH_FORCE_FULL]
		                             : st_reg.mem_ctrl[BIT_DATA_FORCE_FULL];
		ctx_a = refill_is_fetch ? st_reg.ctx_sizes[POS_FETCH_SIZE_A +: 3]
		                        : st_reg.ctx_sizes[POS_DATA_SIZE_A +: 3];
		ctx_b = refill_is_fetch ? st_reg.ctx_sizes[POS_FETCH_SIZE_B +: 3]
		                        : st_reg.ctx_sizes[POS_DATA_SIZE_B +: 3];
		// with selection off only the two fixed sizes fit
		size_ok = size_sel ? (refill_page_size == ctx_a || refill_page_size == ctx_b)
		                   : (refill_page_size == PS_8K || refill_page_size == PS_4M);
		ok_two = (!refill_locked || !refill_global) && size_ok && !force_full;
		set_idx = refill_tag_addr[TAG_IDX_LSB + TAG_IDX_STEP * int'(refill_page_size) +: SET_IDX_W];
	end

	// a lock bit on an empty slot means nothing, so it never blocks reuse
	assign eff_lock   = st_reg.fvalid & st_reg.flock;
	assign all_locked = &eff_lock;
	assign lm_many    = |(lookup_match & (lookup_match - NUM_FULL'(1)));

	trs_low_pick #(.N(NUM_FULL), .W(FULL_IDX_W)) u_pick_invalid (
		.req   (~st_reg.fvalid),
		.found (inv_found),
		.idx   (inv_idx)
	);
	trs_low_pick #(.N(NUM_FULL), .W(FULL_IDX_W)) u_pick_unused (
		.req   (~st_reg.fused & ~eff_lock),
		.found (uu_found),
		.idx   (uu_idx)
	);
	trs_low_pick #(.N(NUM_FULL), .W(FULL_IDX_W)) u_pick_unlocked (
		.req   (~eff_lock),
		.found (ul_found),
		.idx   (ul_idx)
	);
	trs_low_pick #(.N(NUM_FULL), .W(FULL_IDX_W)) u_pick_match (
		.req   (lookup_match),
		.found (lm_found),
		.idx   (lm_idx)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// ==================================================================
	// next state
	logic [31:0] wv;
	logic [2:0]  ev;
	logic        wr_go;
	logic        rd_go;

	always_comb
	begin
		st_next = st_reg;
		ev      = 3'h0;
		wv      = 32'h0;
		wr_go   = 1'b0;
		rd_go   = s_axi_arvalid && !st_reg.rvalid;
		st_next.r_done = 1'b0;
		st_next.r_drop = 1'b0;
		st_next.a_done = 1'b0;
		st_next.l_hit  = 1'b0;
		st_next.l_multi = 1'b0;

		// lookups: lowest match serves, identical pairs are harmless
		if (lookup_valid && lm_found)
		begin
			st_next.l_hit   = 1'b1;
			st_next.l_entry = lm_idx;
			st_next.l_multi = lm_many && !lookup_identical;
			st_next.fused[lm_idx] = 1'b1;
		end

		// automatic refill
		if (refill_valid)
		begin
			st_next.r_done = 1'b1;
			st_next.r_two  = ok_two;
			st_next.r_set  = set_idx;
			if (ok_two)
			begin
				st_next.refills = st_reg.refills + 32'h1;
				if (!st_reg.tvalid[set_idx][0])
					st_next.r_way = 1'b0;
				else if (!st_reg.tvalid[set_idx][1])
					st_next.r_way = 1'b1;
				else
					st_next.r_way = st_reg.tnext[set_idx];
				st_next.tvalid[set_idx][st_next.r_way] = 1'b1;
				st_next.tnext[set_idx] = !st_next.r_way;
			end
			else if (all_locked)
			begin
				st_next.r_drop = 1'b1;
			end
			else
			begin
				st_next.refills = st_reg.refills + 32'h1;
				if (inv_found)
					st_next.r_entry = inv_idx;
				else if (uu_found)
					st_next.r_entry = uu_idx;
				else
				begin
					// after the clear every unlocked entry counts as unused
					st_next.fused   = '0;
					st_next.r_entry = ul_idx;
				end
				st_next.fvalid[st_next.r_entry] = 1'b1;
				st_next.flock[st_next.r_entry]  = refill_locked;
			end
		end

		// software writes go straight in, no placement
		if (direct_full_we)
		begin
			st_next.fvalid[direct_full_entry] = direct_full_valid;
			st_next.flock[direct_full_entry]  = direct_full_lock;
			st_next.fused[direct_full_entry]  = 1'b0;
		end
		if (direct_two_we)
			st_next.tvalid[direct_two_set][direct_two_way] = direct_two_valid;

		// identifier choice and privilege check
		if (access_valid)
		begin
			if (!access_alternate)
				sel_asi = access_implicit_asi;
			else if (access_use_imm)
				sel_asi = access_imm_asi;
			else
				sel_asi = access_asi_reg;
			st_next.a_done = 1'b1;
			st_next.a_asi  = sel_asi;
			st_next.a_trap = !privilege_flag && sel_asi <= ASI_PRIV_MAX;
		end
		else
		begin
			sel_asi = 8'h00;
		end

		ev[EV_DROPPED]   = st_next.r_drop;
		ev[EV_MULTI_HIT] = st_next.l_multi;
		ev[EV_PRIV_TRAP] = st_next.a_done && st_next.a_trap;

		// write channel
		case (st_reg.wst)
			W_IDLE:
			begin
				if (s_axi_awvalid && !st_reg.aw_got)
				begin
					st_next.aw_got = 1'b1;
					st_next.awaddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !st_reg.w_got)
				begin
					st_next.w_got = 1'b1;
					st_next.wdata = s_axi_wdata;
					st_next.wstrb = s_axi_wstrb;
				end
				wr_go = st_next.aw_got && st_next.w_got;
			end
			W_RESP:
			begin
				if (s_axi_bready)
					st_next.wst = W_IDLE;
			end
			default:
			begin
				st_next.wst = W_IDLE;
			end
		endcase

		// new events win over a clear in the same cycle
		st_next.status = st_reg.status | ev;
		if (wr_go)
		begin
			st_next.wst    = W_RESP;
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bresp  = RESP_OKAY;
			case (st_next.awaddr)
				OFF_MEM_CTRL:
				begin
					wv = merge({28'h0, st_reg.mem_ctrl}, st_next.wdata, st_next.wstrb);
					st_next.mem_ctrl = wv[3:0];
				end
				OFF_CTX_SIZES:
				begin
					wv = merge({16'h0, st_reg.ctx_sizes}, st_next.wdata, st_next.wstrb);
					st_next.ctx_sizes = wv[15:0] & 16'h7777;
				end
				OFF_STATUS:
				begin
					wv = merge(32'h0, st_next.wdata, st_next.wstrb);
					st_next.status = (st_reg.status & ~wv[2:0]) | ev;
				end
				OFF_MASK:
				begin
					wv = merge({29'h0, st_reg.mask}, st_next.wdata, st_next.wstrb);
					st_next.mask = wv[2:0];
				end
				OFF_FULL_VLD, OFF_FULL_LOCK, OFF_FULL_USED, OFF_REFILLS:
				begin
					// state views are read-only; writes are dropped quietly
					wv = 32'h0;
				end
				default:
				begin
					st_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		// read channel
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (rd_go)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = RESP_OKAY;
			case (s_axi_araddr)
				OFF_MEM_CTRL:  st_next.rdata = {28'h0, st_reg.mem_ctrl};
				OFF_CTX_SIZES: st_next.rdata = {16'h0, st_reg.ctx_sizes};
				OFF_STATUS:    st_next.rdata = {29'h0, st_reg.status};
				OFF_MASK:      st_next.rdata = {29'h0, st_reg.mask};
				OFF_FULL_VLD:  st_next.rdata = 32'(st_reg.fvalid);
				OFF_FULL_LOCK: st_next.rdata = 32'(st_reg.flock);
				OFF_FULL_USED: st_next.rdata = 32'(st_reg.fused);
				OFF_REFILLS:   st_next.rdata = st_reg.refills;
				default:
				begin
					st_next.rdata = 32'h0;
					st_next.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg           <= '0;
			st_reg.wst       <= W_IDLE;
			st_reg.mem_ctrl  <= MEM_CTRL_RST;
			st_reg.ctx_sizes <= CTX_SIZES_RST;
			st_reg.status    <= STATUS_RST;
			st_reg.mask      <= MASK_RST;
		end
		else if (ce)
		begin
			st_reg <= st_next;
		end
	end

	// ==================================================================
	// outputs
	assign s_axi_awready     = (st_reg.wst == W_IDLE) && !st_reg.aw_got;
	assign s_axi_wready      = (st_reg.wst == W_IDLE) && !st_reg.w_got;
	assign s_axi_bvalid      = (st_reg.wst == W_RESP);
	assign s_axi_bresp       = st_reg.bresp;
	assign s_axi_arready     = !st_reg.rvalid;
	assign s_axi_rvalid      = st_reg.rvalid;
	assign s_axi_rdata       = st_reg.rdata;
	assign s_axi_rresp       = st_reg.rresp;
	assign irq               = |(st_reg.status & st_reg.mask);
	assign refill_done       = st_reg.r_done;
	assign refill_to_two_way = st_reg.r_two;
	assign refill_dropped    = st_reg.r_drop;
	assign refill_entry      = st_reg.r_entry;
	assign refill_set_index  = st_reg.r_set;
	assign refill_way        = st_reg.r_way;
	assign lookup_hit        = st_reg.l_hit;
	assign lookup_entry      = st_reg.l_entry;
	assign lookup_multi_hit  = st_reg.l_multi;
	assign access_done       = st_reg.a_done;
	assign access_asi        = st_reg.a_asi;
	assign access_priv_trap  = st_reg.a_trap;

	// ==================================================================
	// checks
	a_lock_global_full: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && refill_locked && refill_global |=> refill_done && !refill_to_two_way)
		else $error("locked global refill sent to two-way buffer");
	a_size_fixed_check: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && !size_sel && refill_page_size != PS_8K
		&& refill_page_size != PS_4M |=> !refill_to_two_way)
		else $error("odd page size placed in two-way buffer");
	a_force_full_side: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && force_full |=> !refill_to_two_way)
		else $error("force-full bit ignored");
	a_set_index_pick: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && ok_two |=> refill_to_two_way
		&& refill_set_index == $past(set_idx))
		else $error("two-way set index wrong");
	a_first_invalid: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && !ok_two && inv_found |=> !refill_dropped
		&& refill_entry == $past(inv_idx))
		else $error("not the lowest invalid entry");
	a_unused_unlocked: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && !ok_two && !inv_found && uu_found
		|=> refill_entry == $past(uu_idx))
		else $error("not the lowest unused unlocked entry");
	a_used_clear_all: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && !ok_two && !inv_found && !uu_found && !all_locked
		|=> st_reg.fused == '0 && refill_entry == $past(ul_idx))
		else $error("used bits not cleared on retry");
	a_drop_all_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && refill_valid && !ok_two && all_locked && !direct_full_we
		|=> refill_dropped && $stable(st_reg.fvalid) && $stable(st_reg.flock))
		else $error("refill not dropped with all entries locked");
	a_identical_no_err: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && lookup_valid && lm_found && lookup_identical |=> lookup_hit && !lookup_multi_hit)
		else $error("identical entries flagged as multi-hit");
	a_hit_sets_used: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && lookup_valid && lm_found && !refill_valid && !direct_full_we
		|=> st_reg.fused[lookup_entry])
		else $error("hit entry not marked used");
	a_implicit_ident: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && access_valid && !access_alternate |=> access_asi == $past(access_implicit_asi))
		else $error("implicit identifier not used");
	a_priv_trap_low: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && access_valid && access_alternate && !access_use_imm && !privilege_flag
		&& access_asi_reg <= ASI_PRIV_MAX |=> access_done && access_priv_trap)
		else $error("unprivileged low identifier not trapped");
endmodule

//--- src/trs_pkg.sv
package trs_pkg;

	// ==================================================================
	// register byte offsets
	localparam logic [7:0] OFF_MEM_CTRL  = 8'h00;
	localparam logic [7:0] OFF_CTX_SIZES = 8'h04;
	localparam logic [7:0] OFF_STATUS    = 8'h08;
	localparam logic [7:0] OFF_MASK      = 8'h0C;
	localparam logic [7:0] OFF_FULL_VLD  = 8'h10;
	localparam logic [7:0] OFF_FULL_LOCK = 8'h14;
	localparam logic [7:0] OFF_FULL_USED = 8'h18;
	localparam logic [7:0] OFF_REFILLS   = 8'h1C;

	// ==================================================================
	// memory_control_reg fields
	localparam int BIT_FETCH_SIZE_SELECT = 0;
	localparam int BIT_DATA_SIZE_SELECT  = 1;
	localparam int BIT_FETCH_FORCE_FULL  = 2;
	localparam int BIT_DATA_FORCE_FULL   = 3;
	localparam logic [3:0] MEM_CTRL_RST  = 4'h0;

	// context page size fields, three bits each
	localparam int POS_FETCH_SIZE_A = 0;
	localparam int POS_FETCH_SIZE_B = 4;
	localparam int POS_DATA_SIZE_A  = 8;
	localparam int POS_DATA_SIZE_B  = 12;
	localparam logic [15:0] CTX_SIZES_RST = 16'h0000;

	// status / mask bits
	localparam int EV_DROPPED   = 0;
	localparam int EV_MULTI_HIT = 1;
	localparam int EV_PRIV_TRAP = 2;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST   = 3'h0;

	// ==================================================================
	// page sizes and identifiers
	localparam logic [2:0] PS_8K = 3'h0;
	localparam logic [2:0] PS_4M = 3'h3;
	localparam int TAG_IDX_LSB = 13;
	localparam int TAG_IDX_STEP = 3;
	localparam logic [7:0] ASI_PRIV_MAX = 8'h7F;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		W_IDLE = 2'b01,
		W_RESP = 2'b10
	} trs_wstate_t;

endpackage

//--- src/trs_low_pick.sv
`timescale 1ns/1ps
module trs_low_pick #(
	parameter int N = 16,
	parameter int W = 4
) (
	input  wire logic [N-1:0] req,
	output logic              found,
	output logic [W-1:0]      idx
);
	// scans downward so the lowest set bit is the last one written
	always_comb
	begin
		found = 1'b0;
		idx   = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				found = 1'b1;
				idx   = W'(i);
			end
		end
	end
endmodule

//--- tb/trs_core_model.sv
`timescale 1ns/1ps
module trs_core_model (
	input  wire logic   aclk,
	output logic        refill_valid,
	output logic        refill_is_fetch,
	output logic [2:0]  refill_page_size,
	output logic        refill_locked,
	output logic        refill_global,
	output logic [47:0] refill_tag_addr,
	output logic        lookup_valid,
	output logic [15:0] lookup_match,
	output logic        lookup_identical,
	output logic        direct_full_we,
	output logic [3:0]  direct_full_entry,
	output logic        direct_full_valid,
	output logic        direct_full_lock,
	output logic        access_valid,
	output logic        access_alternate,
	output logic        access_use_imm,
	output logic [7:0]  access_imm_asi,
	output logic [7:0]  access_asi_reg,
	output logic [7:0]  access_implicit_asi,
	output logic        privilege_flag
);
	logic [54:0] rq;
	logic [17:0] lq;
	logic [6:0]  dq;
	logic [27:0] aq;
	assign {refill_valid, refill_is_fetch, refill_page_size, refill_locked, refill_global,
		refill_tag_addr} = rq;
	assign {lookup_valid, lookup_match, lookup_identical} = lq;
	assign {direct_full_we, direct_full_entry, direct_full_valid, direct_full_lock} = dq;
	assign {access_valid, access_alternate, access_use_imm, access_imm_asi, access_asi_reg,
		access_implicit_asi, privilege_flag} = aq;
	initial
	begin
		rq = '0;
		lq = '0;
		dq = '0;
		aq = '0;
	end
	// ==================================================================
	// pulses; fields invert afterwards so stale values never help
	task automatic refill(input logic [53:0] f);
		// never offers one address with two sizes
		rq <= {1'b1, f};
		@(posedge aclk);
		rq <= {1'b0, ~f};
		@(posedge aclk);
	endtask
	task automatic lookup(input logic [16:0] f);
		lq <= {1'b1, f};
		@(posedge aclk);
		lq <= {1'b0, ~f};
		@(posedge aclk);
	endtask
	task automatic dfull(input logic [5:0] f);
		dq <= {1'b1, f};
		@(posedge aclk);
		dq <= {1'b0, ~f};
		@(posedge aclk);
	endtask
	task automatic access(input logic [26:0] f);
		aq <= {1'b1, f};
		@(posedge aclk);
		aq <= {1'b0, ~f};
		@(posedge aclk);
	endtask
endmodule

//--- tb/trs_tlb_replacement_select_test.sv
`timescale 1ns/1ps
module trs_tlb_replacement_select_test;
	import trs_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, access_imm_asi, access_asi_reg;
	logic [7:0] access_implicit_asi, access_asi;
	logic [31:0] s_axi_wdata, s_axi_rdata, obs, lf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb, refill_entry, lookup_entry, direct_full_entry;
	logic refill_valid, refill_is_fetch, refill_locked, refill_global, refill_done, refill_way;
	logic refill_to_two_way, refill_dropped, lookup_valid, lookup_identical, lookup_hit;
	logic lookup_multi_hit, direct_full_we, direct_full_valid, direct_full_lock, access_valid;
	logic access_alternate, access_use_imm, privilege_flag, access_done, access_priv_trap;
	logic [2:0] refill_page_size;
	logic [47:0] refill_tag_addr;
	logic [5:0] refill_set_index;
	logic [15:0] lookup_match;
	logic [31:0] q[$];
	int fail_count, checked;
	bit [63:0] wp;
	trs_tlb_replacement_select uut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .refill_valid,
		.refill_is_fetch, .refill_page_size, .refill_locked, .refill_global, .refill_tag_addr,
		.refill_done, .refill_to_two_way, .refill_dropped, .refill_entry, .refill_set_index,
		.refill_way, .lookup_valid, .lookup_match, .lookup_identical, .lookup_hit,
		.lookup_entry, .lookup_multi_hit, .direct_full_we, .direct_full_entry,
		.direct_full_valid, .direct_full_lock, .direct_two_we(1'b0), .direct_two_set(6'h00),
		.direct_two_way(1'b0), .direct_two_valid(1'b0), .access_valid, .access_alternate,
		.access_use_imm, .access_imm_asi, .access_asi_reg, .access_implicit_asi,
		.privilege_flag, .access_done, .access_asi, .access_priv_trap);
	trs_core_model m (.aclk, .refill_valid, .refill_is_fetch, .refill_page_size,
		.refill_locked, .refill_global, .refill_tag_addr, .lookup_valid, .lookup_match,
		.lookup_identical, .direct_full_we, .direct_full_entry, .direct_full_valid,
		.direct_full_lock, .access_valid, .access_alternate, .access_use_imm, .access_imm_asi,
		.access_asi_reg, .access_implicit_asi, .privilege_flag);
	// ==================================================================
	// checking
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("mismatches %0d checks %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// one result per cycle at most, so a single priority pick suffices
	always @(posedge aclk)
	begin
		if (aresetn && (refill_done || access_done || lookup_hit || s_axi_rvalid || s_axi_bvalid))
		begin
			obs = refill_done ? {4'h1, 15'h0, refill_way & refill_to_two_way,
				refill_to_two_way ? refill_set_index : 6'h00,
				refill_to_two_way, refill_dropped,
				(refill_to_two_way | refill_dropped) ? 4'h0 : refill_entry}
				: access_done ? {4'h2, 19'h0, access_priv_trap, access_asi}
				: lookup_hit ? {4'h4, 22'h0, lookup_multi_hit, lookup_entry, 1'b1}
				: s_axi_bvalid ? {4'h5, 26'h0, s_axi_bresp}
				: {4'h3, 9'h0, s_axi_rresp, irq, s_axi_rdata[15:0]};
			chk("result", obs, q.size() > 0 ? q.pop_front() : 32'hFFFFFFFF);
		end
	end
	// ==================================================================
	// bus and request tasks
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw;
		q.push_back({4'h5, 26'h0, a <= OFF_REFILLS ? RESP_OKAY : RESP_SLVERR});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		{pa, pw} = 2'b11;
		// each channel is released on its own take
		do
		begin
			@(posedge aclk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		while (pa || pw);
		do @(posedge aclk); while (!s_axi_bvalid);
	endtask
	task rd(input logic [7:0] a, input logic [1:0] r, input logic i, input logic [15:0] v);
		q.push_back({4'h3, 9'h0, r, i, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
	endtask
	task rf(input logic f, input logic [2:0] p, input logic k, g, t2, dr, input logic [3:0] e);
		logic [47:0] t;
		logic [5:0]  s;
		lf = lfsr(lf);
		t = {lf[15:0], lf};
		s = t2 ? t[TAG_IDX_LSB + TAG_IDX_STEP * p +: 6] : 6'h00;
		// no two-way entry is ever invalidated here, so ways alternate per set
		q.push_back({4'h1, 15'h0, t2 & wp[s], s, t2, dr, e});
		wp[s] = wp[s] ^ t2;
		m.refill({f, p, k, g, t});
	endtask
	task lk(input logic [15:0] mt, input logic id, mh, input logic [3:0] e);
		q.push_back({4'h4, 22'h0, mh, e, 1'b1});
		m.lookup({mt, id});
	endtask
	task ac(input logic al, im, pr);
		logic [7:0] a;
		lf = lfsr(lf);
		a = !al ? lf[7:0] : im ? lf[23:16] : lf[15:8];
		q.push_back({4'h2, 19'h0, !pr && a <= ASI_PRIV_MAX, a});
		m.access({al, im, lf[23:0], pr});
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial
	begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		end_sim;
	end
	// ==================================================================
	// main sequence
	initial
	begin
		int i;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready} = 2'b11;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		lf = 32'h777B;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_STATUS, RESP_OKAY, 1'b0, 16'h0000);
		rd(8'h40, RESP_SLVERR, 1'b0, 16'h0000);
		wr(8'h40, 32'h00000001);
		rf(1'b1, PS_8K, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
		rf(1'b1, PS_4M, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
		rf(1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		rf(1'b0, PS_8K, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1);
		wr(OFF_CTX_SIZES, 32'h00002100);
		wr(OFF_MEM_CTRL, 32'h00000002);
		rf(1'b0, 3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
		rf(1'b0, PS_8K, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2);
		rf(1'b1, PS_8K, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
		wr(OFF_MEM_CTRL, 32'h0000000E);
		rf(1'b1, PS_8K, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3);
		rf(1'b0, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4);
		rd(OFF_FULL_VLD, RESP_OKAY, 1'b0, 16'h001F);
		lk(16'h0003, 1'b1, 1'b0, 4'h0);
		lk(16'h0006, 1'b0, 1'b1, 4'h1);
		rd(OFF_STATUS, RESP_OKAY, 1'b0, 16'h0002);
		wr(OFF_MASK, 32'h00000007);
		for (i = 0; i < 16; i++)
			m.dfull({i[3:0], 2'b11});
		rf(1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
		rd(OFF_FULL_LOCK, RESP_OKAY, 1'b1, 16'hFFFF);
		rd(OFF_STATUS, RESP_OKAY, 1'b1, 16'h0003);
		wr(OFF_STATUS, 32'h00000003);
		rd(OFF_STATUS, RESP_OKAY, 1'b0, 16'h0000);
		m.dfull({4'h9, 2'b10});
		rf(1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
		lk(16'h0200, 1'b1, 1'b0, 4'h9);
		rd(OFF_FULL_USED, RESP_OKAY, 1'b0, 16'h0200);
		rf(1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
		rd(OFF_FULL_USED, RESP_OKAY, 1'b0, 16'h0000);
		for (i = 0; i < 16; i++)
			ac(i[0], i[1], i[2]);
		repeat (4) @(posedge aclk);
		chk("pending", q.size(), 32'h0);
		end_sim;
	end
endmodule
